// [include/smc_consts.svh]
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_ADDR_CTRL 8'h00
`define SMC_ADDR_STAT 8'h04
`define SMC_ADDR_PCLK 8'h08
`define SMC_ADDR_IRQ_STAT 8'h0C
`define SMC_ADDR_IRQ_MASK 8'h10
`define SMC_CTRL_EN_BIT 0
`define SMC_CTRL_MODE_LSB 1
`define SMC_CTRL_RESET 4'h0
`define SMC_PCLK_RESET 8'h00
`define SMC_NUM_PERIPH 8
`define SMC_CPU_HOLD_CYCLES 3'h4
`define SMC_IRQ_SLEEP_BIT 0
`define SMC_IRQ_WAKE_BIT 1
`endif

// [include/smc_pkg.sv]
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_MODE_IDLE = 3'h0,
    SMC_MODE_PDOWN = 3'h2,
    SMC_MODE_PSAVE = 3'h3,
    SMC_MODE_STBY = 3'h6,
    SMC_MODE_ESTBY = 3'h7
  } smc_mode_t;
  typedef enum logic [1:0] {
    SMC_ST_ACTIVE = 2'b00,
    SMC_ST_SLEEP = 2'b01,
    SMC_ST_WAKE = 2'b11
  } smc_state_t;
endpackage

// [src/smc_axil_slave.sv]
`include "smc_consts.svh"
`default_nettype none
module smc_axil_slave (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i,
  input wire logic wr_ok_i
);
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_write;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rd_addr_o = s_axi_araddr;
  assign do_write = aw_have_reg && w_have_reg;
  assign wr_stb_o = do_write;
  assign wr_addr_o = awaddr_reg;
  assign wr_data_o = wdata_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok_i ? 2'h0 : 2'h2;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_ok_i ? rd_data_i : 32'h0000_0000;
      rresp_next = rd_ok_i ? 2'h0 : 2'h2;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
endmodule
`default_nettype wire

// [src/smc_sleep_ctrl.sv]
`include "smc_consts.svh"
`default_nettype none
module smc_sleep_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr_i,
  input wire logic rtc_enable_i,
  input wire logic osc_enable_i,
  input wire logic wake_addr_match_i,
  input wire logic wake_pin_change_i,
  input wire logic wake_bus_resume_i,
  input wire logic wake_rtc_ovf_i,
  input wire logic wake_rtc_cmp_i,
  input wire logic wake_other_irq_i,
  output logic cpu_clk_en_o,
  output logic [7:0] per_clk_en_o,
  output logic sys_clk_en_o,
  output logic rtc_clk_en_o,
  output logic osc_run_o,
  output logic sleeping_o,
  output logic irq_o
);
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [7:0] pstop_reg, pstop_next;
  logic [1:0] istat_reg, istat_next;
  logic [1:0] imask_reg, imask_next;
  smc_pkg::smc_state_t state_reg, state_next;
  smc_pkg::smc_mode_t mode_reg, mode_next;
  logic [2:0] hold_reg, hold_next;
  logic wake_any;
  logic ev_sleep;
  logic ev_wake;
  logic [2:0] sel_mode;

  smc_axil_slave u_bus (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok),
    .wr_ok_i(wr_ok)
  );

  // Legal mode encodings only
  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m == smc_pkg::SMC_MODE_IDLE) || (m == smc_pkg::SMC_MODE_PDOWN) ||
                 (m == smc_pkg::SMC_MODE_PSAVE) || (m == smc_pkg::SMC_MODE_STBY) ||
                 (m == smc_pkg::SMC_MODE_ESTBY);
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `SMC_ADDR_CTRL) || (a == `SMC_ADDR_STAT) || (a == `SMC_ADDR_PCLK) ||
                 (a == `SMC_ADDR_IRQ_STAT) || (a == `SMC_ADDR_IRQ_MASK);
  endfunction

  assign sel_mode = ctrl_reg[`SMC_CTRL_MODE_LSB +: 3];
  assign rd_ok = addr_known(rd_addr);
  assign wr_ok = addr_known(wr_addr);

  // Wake sources per mode
  always_comb begin
    wake_any = wake_addr_match_i || wake_pin_change_i || wake_bus_resume_i;
    unique case (mode_reg)
      smc_pkg::SMC_MODE_IDLE: wake_any = wake_any || wake_other_irq_i || wake_rtc_ovf_i ||
                                         wake_rtc_cmp_i;
      smc_pkg::SMC_MODE_PSAVE,
      smc_pkg::SMC_MODE_ESTBY: wake_any = wake_any || (rtc_enable_i &&
                                          (wake_rtc_ovf_i || wake_rtc_cmp_i));
      smc_pkg::SMC_MODE_PDOWN,
      smc_pkg::SMC_MODE_STBY: wake_any = wake_any;
    endcase
  end

  // Sleep sequencer
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    hold_next = hold_reg;
    ev_sleep = 1'b0;
    ev_wake = 1'b0;
    unique case (state_reg)
      smc_pkg::SMC_ST_ACTIVE: begin
        if (sleep_instr_i && ctrl_reg[`SMC_CTRL_EN_BIT] && mode_legal(sel_mode)) begin
          mode_next = smc_pkg::smc_mode_t'(sel_mode);
          state_next = smc_pkg::SMC_ST_SLEEP;
          ev_sleep = 1'b1;
        end
      end
      smc_pkg::SMC_ST_SLEEP: begin
        if (wake_any) begin
          state_next = smc_pkg::SMC_ST_WAKE;
          hold_next = `SMC_CPU_HOLD_CYCLES;
          ev_wake = 1'b1;
        end
      end
      smc_pkg::SMC_ST_WAKE: begin
        hold_next = hold_reg - 3'h1;
        if (hold_reg == 3'h1) begin
          state_next = smc_pkg::SMC_ST_ACTIVE;
        end
      end
      default: state_next = smc_pkg::SMC_ST_ACTIVE;
    endcase
  end

  // Clock gating per mode
  always_comb begin
    cpu_clk_en_o = (state_reg == smc_pkg::SMC_ST_ACTIVE);
    sys_clk_en_o = 1'b1;
    rtc_clk_en_o = rtc_enable_i;
    osc_run_o = 1'b1;
    per_clk_en_o = ~pstop_reg;
    if (state_reg == smc_pkg::SMC_ST_SLEEP) begin
      unique case (mode_reg)
        smc_pkg::SMC_MODE_IDLE: begin
          cpu_clk_en_o = 1'b0;
        end
        smc_pkg::SMC_MODE_PDOWN: begin
          sys_clk_en_o = 1'b0;
          rtc_clk_en_o = 1'b0;
          osc_run_o = 1'b0;
          per_clk_en_o = 8'h00;
        end
        smc_pkg::SMC_MODE_PSAVE: begin
          sys_clk_en_o = 1'b0;
          osc_run_o = 1'b0;
          per_clk_en_o = 8'h00;
        end
        smc_pkg::SMC_MODE_STBY: begin
          sys_clk_en_o = 1'b0;
          rtc_clk_en_o = 1'b0;
          osc_run_o = osc_enable_i;
          per_clk_en_o = 8'h00;
        end
        smc_pkg::SMC_MODE_ESTBY: begin
          sys_clk_en_o = 1'b0;
          osc_run_o = osc_enable_i;
          per_clk_en_o = 8'h00;
        end
      endcase
    end
    sleeping_o = (state_reg != smc_pkg::SMC_ST_ACTIVE);
    irq_o = |(istat_reg & imask_reg);
  end

  // Registers; state kept across sleep
  always_comb begin
    ctrl_next = ctrl_reg;
    pstop_next = pstop_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    if (wr_stb) begin
      unique case (wr_addr)
        `SMC_ADDR_CTRL: ctrl_next = wr_data[3:0];
        `SMC_ADDR_PCLK: pstop_next = wr_data;
        `SMC_ADDR_IRQ_MASK: imask_next = wr_data[1:0];
        `SMC_ADDR_IRQ_STAT: istat_next = istat_reg & ~wr_data[1:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (ev_sleep) begin
      istat_next[`SMC_IRQ_SLEEP_BIT] = 1'b1;
    end
    if (ev_wake) begin
      istat_next[`SMC_IRQ_WAKE_BIT] = 1'b1;
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `SMC_ADDR_CTRL: rd_data[3:0] = ctrl_reg;
      `SMC_ADDR_STAT: rd_data[7:0] = {hold_reg, mode_reg, state_reg};
      `SMC_ADDR_PCLK: rd_data[7:0] = pstop_reg;
      `SMC_ADDR_IRQ_STAT: rd_data[1:0] = istat_reg;
      `SMC_ADDR_IRQ_MASK: rd_data[1:0] = imask_reg;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= smc_pkg::SMC_ST_ACTIVE;
      mode_reg <= smc_pkg::SMC_MODE_IDLE;
      hold_reg <= 3'h0;
      ctrl_reg <= `SMC_CTRL_RESET;
      pstop_reg <= `SMC_PCLK_RESET;
      istat_reg <= 2'h0;
      imask_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      hold_reg <= hold_next;
      ctrl_reg <= ctrl_next;
      pstop_reg <= pstop_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
    end
  end
endmodule
`default_nettype wire

// [verification/smc_core_model.sv]
`default_nettype none
module smc_core_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sleep_req_i,
  input wire logic [5:0] wake_req_i,
  input wire logic cpu_clk_en_i,
  output logic sleep_instr_o,
  output logic [5:0] wake_o
);
  logic cpu_q;
  // Core issues sleep only while clocked; sources hold until core restarts
  always_ff @(posedge clk_sys_i) begin
    cpu_q <= cpu_clk_en_i;
    sleep_instr_o <= rst_n_i && sleep_req_i && cpu_clk_en_i;
    if (!rst_n_i || (cpu_clk_en_i && !cpu_q)) begin
      wake_o <= 6'h00;
    end else begin
      wake_o <= wake_o | wake_req_i;
    end
  end
endmodule
`default_nettype wire

// [verification/smc_sleep_ctrl_asserts.sv]
`default_nettype none
module smc_sleep_ctrl_asserts (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sleep_instr_i,
  input wire logic rtc_enable_i,
  input wire logic wake_addr_match_i,
  input wire logic wake_pin_change_i,
  input wire logic wake_bus_resume_i,
  input wire logic wake_rtc_ovf_i,
  input wire logic wake_rtc_cmp_i,
  input wire logic cpu_clk_en_o,
  input wire logic [7:0] per_clk_en_o,
  input wire logic sys_clk_en_o,
  input wire logic rtc_clk_en_o,
  input wire logic osc_run_o,
  input wire logic sleeping_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_CPU_OFF: assert property (sleeping_o |-> !cpu_clk_en_o)
    else $error("cpu clock on in sleep");
  AST_CPU_HOLD: assert property ($rose(sys_clk_en_o) && sleeping_o |->
    !cpu_clk_en_o [*4] ##1 cpu_clk_en_o) else $error("cpu hold not four");
  AST_PDOWN_GATE: assert property (sleeping_o && !osc_run_o |->
    !sys_clk_en_o && per_clk_en_o == 8'h00) else $error("clocks on with osc off");
  AST_STBY_GATE: assert property (sleeping_o && !sys_clk_en_o |->
    per_clk_en_o == 8'h00 && !cpu_clk_en_o) else $error("standby gating");
  AST_RTC_FOLLOW: assert property (rtc_clk_en_o |-> rtc_enable_i)
    else $error("counter clock without enable");
  AST_ENTRY: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
    else $error("sleep without instruction");
  AST_PDOWN_HOLD: assert property (sleeping_o && !osc_run_o && !rtc_clk_en_o &&
    !(wake_addr_match_i || wake_pin_change_i || wake_bus_resume_i) |=> !sys_clk_en_o)
    else $error("woke from bad source");
  AST_WAKE_PIN: assert property (sleeping_o && !sys_clk_en_o &&
    (wake_addr_match_i || wake_pin_change_i || wake_bus_resume_i) |=> sys_clk_en_o)
    else $error("no wake on pin source");
  AST_RTC_WAKE: assert property (sleeping_o && !sys_clk_en_o && rtc_clk_en_o &&
    (wake_rtc_ovf_i || wake_rtc_cmp_i) |=> sys_clk_en_o) else $error("no counter wake");
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_asserts smc_sleep_ctrl_asserts_inst (.*);
`default_nettype wire

// [verification/tb_sleep_mode_controller.sv]
`include "smc_consts.svh"
`default_nettype none
module tb_sleep_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] c;
    logic r, o, sys, rtc, osc;
    logic [7:0] per;
  } smc_row_t;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic sleep_req = 1'h0;
  logic rtc_enable_i = 1'h0;
  logic osc_enable_i = 1'h0;
  logic [5:0] wake_req = 6'h00;
  logic [5:0] wk;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sleep_instr_i, wake_addr_match_i, wake_pin_change_i, wake_bus_resume_i;
  logic wake_rtc_ovf_i, wake_rtc_cmp_i, wake_other_irq_i;
  logic cpu_clk_en_o, sys_clk_en_o, rtc_clk_en_o, osc_run_o, sleeping_o, irq_o;
  logic [7:0] per_clk_en_o;
  int failures = 0;
  int checks_done = 0;
  int n;
  smc_row_t rows [6] = '{
    '{8'h01, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'hF0},
    '{8'h05, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 8'h00},
    '{8'h07, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'h00},
    '{8'h07, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 8'h00},
    '{8'h0D, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 8'h00},
    '{8'h0F, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00}};
  always #20 clk_sys_i = ~clk_sys_i;
  smc_sleep_ctrl smc_sleep_ctrl_inst (.*);
  smc_core_model smc_core_model_inst (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sleep_req_i(sleep_req),
    .wake_req_i(wake_req),
    .cpu_clk_en_i(cpu_clk_en_o),
    .sleep_instr_o(sleep_instr_i),
    .wake_o(wk)
  );
  assign {wake_other_irq_i, wake_rtc_cmp_i, wake_rtc_ovf_i} = wk[5:3];
  assign {wake_bus_resume_i, wake_pin_change_i, wake_addr_match_i} = wk[2:0];
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      tick(1);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("CHECK FAILED write response exp 1 got 0");
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      tick(1);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("CHECK FAILED read response exp 1 got 0");
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Mode write, one sleep instruction, then settle
  task automatic nap(input logic [7:0] c);
    wr(`SMC_ADDR_CTRL, c);
    sleep_req <= 1'h1;
    tick(1);
    sleep_req <= 1'h0;
    tick(3);
  endtask
  // Leaves n as cycles from peripheral restart to cpu restart
  task automatic wake(input logic [5:0] w);
    wake_req <= w;
    tick(1);
    wake_req <= 6'h00;
    n = 0;
    while (per_clk_en_o === 8'h00 && n < 40) begin
      tick(1);
      n++;
    end
    n = 0;
    while (cpu_clk_en_o !== 1'h1 && n < 40) begin
      tick(1);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    tick(4000);
    failures++;
    final_report;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    tick(16);
    rst_n_i <= 1'h1;
    tick(1);
    wr(`SMC_ADDR_PCLK, 8'h0F);
    tick(1);
    chk("active per", 32'hF0, per_clk_en_o);
    foreach (rows[i]) begin
      rtc_enable_i <= rows[i].r;
      osc_enable_i <= rows[i].o;
      nap(rows[i].c);
      chk("asleep", 1, sleeping_o);
      chk("cpu", 0, cpu_clk_en_o);
      chk("per", rows[i].per, per_clk_en_o);
      chk("sys", rows[i].sys, sys_clk_en_o);
      chk("rtc", rows[i].rtc, rtc_clk_en_o);
      chk("osc", rows[i].osc, osc_run_o);
      wake(6'h01 << (i % 3));
      chk("awake", 1, cpu_clk_en_o);
    end
    nap(8'h05);
    wake_req <= 6'h38;
    tick(1);
    wake_req <= 6'h00;
    tick(6);
    chk("pdown hold", 1, sleeping_o & ~sys_clk_en_o);
    wake(6'h02);
    chk("cpu hold", 4, n);
    nap(8'h07);
    wake(6'h10);
    chk("rtc wake", 1, cpu_clk_en_o);
    nap(8'h04);
    chk("no enable", 0, sleeping_o);
    nap(8'h03);
    chk("bad mode", 0, sleeping_o);
    chk("irq masked", 0, irq_o);
    wr(`SMC_ADDR_IRQ_MASK, 8'h01);
    tick(1);
    chk("irq on", 1, irq_o);
    wr(`SMC_ADDR_IRQ_STAT, 8'h01);
    tick(1);
    chk("irq clear", 0, irq_o);
    rd(`SMC_ADDR_IRQ_STAT, d, r);
    chk("irq stat", 32'h2, d);
    rd(8'h20, d, r);
    chk("unmapped resp", 2'h2, r);
    chk("unmapped data", 0, d);
    wr(8'h20, 8'h01);
    chk("unmapped wr resp", 2'h2, s_axi_bresp);
    nap(8'h01);
    wake(6'h20);
    chk("idle other wake", 1, cpu_clk_en_o);
    nap(8'h0D);
    rst_n_i <= 1'h0;
    tick(2);
    rst_n_i <= 1'h1;
    tick(1);
    chk("reset cpu", 1, cpu_clk_en_o);
    chk("reset per", 32'hFF, per_clk_en_o);
    chk("reset sleep", 0, sleeping_o);
    final_report;
  end
endmodule
`default_nettype wire
